// *** hdl/apf_framer.sv ***
/*
 * Auxiliary packet framer: stores one supplied packet, builds the general
 * control packet after vertical sync, inserts BCH parity and emits each
 * packet as 36 consecutive bytes; also writes the sink configuration
 * register over the display data channel. Assumes the data-island window
 * stays open for the 36 cycles of a packet once it has started.
 */
`timescale 1ns/100ps
`default_nettype none
module apf_framer
    import apf_pkg::*;
(
    input wire logic clk_sys,               // System clock, 125 MHz.
    input wire logic reset_n,               // Synchronous reset, active low.
    input wire logic pkt_valid,             // Supplied packet word valid.
    input wire logic [31:0] pkt_word,       // Supplied packet word.
    output logic pkt_ready,                 // Store can take a word.
    output logic aux_type_unknown,          // Stored type code neither 0x00-0x0d nor 0x81-0x87.
    input wire logic island_open,           // Data-island slot available.
    input wire logic vsync,                 // Vertical sync level.
    input wire logic avmute_set,            // Set-mute flag for control pkt.
    input wire logic avmute_clear,          // Clear-mute flag for control pkt.
    output logic out_valid,                 // Packet byte valid.
    output logic [7:0] out_byte,            // Packet byte.
    output logic out_first,                 // First byte of a packet.
    output logic out_last,                  // Last byte of a packet.
    output logic out_parity,                // Byte is an inserted parity.
    input wire logic stream_start,          // Pulse: a stream begins.
    input wire logic version_2p0,           // Stream is a 2.0 stream.
    input wire logic sink_presence_detect,  // Sink presence level.
    output logic scrambler_enable,          // Transmit scrambler on.
    output logic link_clock_ratio_flag,     // Link clock ratio in use.
    output logic sink_cfg_busy,             // Sink register write running.
    output logic sink_nack,                 // Sink refused a byte.
    input wire logic ddc_scl_in,            // Channel clock wire level.
    output logic ddc_scl_out,               // Channel clock drive value.
    output logic ddc_scl_oe,                // Channel clock pulled low.
    input wire logic ddc_sda_in,            // Channel data wire level.
    output logic ddc_sda_out,               // Channel data drive value.
    output logic ddc_sda_oe                 // Channel data pulled low.
);
    // Packet intake.
    logic [3:0] wr_cnt_ff;
    logic full_ff, ready_ff, unknown_ff;
    logic wr_fire, nxt_full, tx_done;
    logic [3:0] nxt_wr_cnt;

    function automatic logic type_known(input logic [7:0] t);
        return (t <= TYPE_AUDIO_META) ||
               ((t > TYPE_INFOFRAME) && (t <= (TYPE_INFOFRAME | IF_DRM)));
    endfunction

    assign wr_fire = pkt_valid && ready_ff;
    assign nxt_wr_cnt = tx_done ? 4'h0 : wr_fire ? wr_cnt_ff + 4'h1
                                                 : wr_cnt_ff;
    // The store refuses words after its ninth word until the packet leaves.
    assign nxt_full = tx_done ? 1'b0 : (wr_fire && wr_cnt_ff == WORD_LAST)
                                       ? 1'b1 : full_ff;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_cnt_ff <= 4'h0;
            full_ff <= 1'b0;
            ready_ff <= 1'b0;
            unknown_ff <= 1'b0;
        end else begin
            wr_cnt_ff <= nxt_wr_cnt;
            full_ff <= nxt_full;
            ready_ff <= !nxt_full;
            if (wr_fire && wr_cnt_ff == 4'h0) begin
                unknown_ff <= !type_known(pkt_word[7:0]);
            end
        end
    end

    // General control packet request after vertical sync.
    logic vsync_d_ff, ctl_pend_ff, ctl_set_ff, ctl_clr_ff;
    logic [8:0] ctl_wait_ff;
    logic vs_rise, ctl_go, aux_go;
    apf_tx_state_t tx_ff, nxt_tx;

    assign vs_rise = vsync && !vsync_d_ff;
    assign ctl_go = (tx_ff == TX_IDLE) && island_open && ctl_pend_ff;
    // The first idle cycle after a packet still sees the store full; without
    // the tx_done term the same packet would leave a second time.
    assign aux_go = (tx_ff == TX_IDLE) && island_open && !ctl_pend_ff
                    && full_ff && !tx_done;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            vsync_d_ff <= 1'b0;
            ctl_pend_ff <= 1'b0;
            ctl_set_ff <= 1'b0;
            ctl_clr_ff <= 1'b0;
            ctl_wait_ff <= 9'h000;
        end else begin
            vsync_d_ff <= vsync;
            if (vs_rise) begin
                ctl_pend_ff <= 1'b1;
                ctl_set_ff <= avmute_set;
                ctl_clr_ff <= avmute_clear;
            end else if (ctl_go) begin
                ctl_pend_ff <= 1'b0;
            end
            ctl_wait_ff <= !ctl_pend_ff ? 9'h000 :
                           island_open ? ctl_wait_ff + 9'h001 : ctl_wait_ff;
        end
    end

    // Byte sequencer: stage one addresses the store, stage two emits.
    logic [5:0] idx_ff, idx_d_ff;
    logic run_d_ff, ctl_ff, ctl_d_ff;
    logic [4:0] body_n_d;
    logic [4:0] body_n;
    logic [3:0] rd_word;
    logic is_par_d;
    logic [1:0] lane_d;
    logic [7:0] data_d, mem_byte, ctl_byte, sel_byte, ecc_val;
    logic [31:0] rd_data;

    function automatic logic [4:0] body_index(input logic [5:0] i);
        logic [5:0] j;
        j = i - BODY_FIRST_IDX;
        return 5'(j[5:3] * 3'd7) + {2'b00, j[2:0]};
    endfunction

    function automatic logic parity_slot(input logic [5:0] i);
        logic [5:0] j;
        j = i - BODY_FIRST_IDX;
        return (i == HDR_PARITY_IDX) ||
               ((i >= BODY_FIRST_IDX) && (j[2:0] == 3'h7));
    endfunction

    assign body_n = body_index(idx_ff);
    assign body_n_d = body_index(idx_d_ff);
    assign rd_word = (idx_ff < BODY_FIRST_IDX) ? 4'h0
                     : {1'b0, body_n[4:2]} + 4'h1;
    assign is_par_d = parity_slot(idx_d_ff);
    assign lane_d = (idx_d_ff < BODY_FIRST_IDX) ? idx_d_ff[1:0]
                    : body_n_d[1:0];
    assign mem_byte = rd_data[8 * lane_d +: 8];
    // Only the type byte and the mute byte of the control packet are
    // non-zero; the other fields stay at their default meaning.
    assign ctl_byte = (idx_d_ff == 6'h00) ? TYPE_GEN_CTRL :
                      (idx_d_ff == BODY_FIRST_IDX)
                      ? {3'h0, ctl_clr_ff, 3'h0, ctl_set_ff} : 8'h00;
    assign data_d = ctl_d_ff ? ctl_byte : mem_byte;
    assign sel_byte = is_par_d ? ecc_val : data_d;
    assign tx_done = run_d_ff && !ctl_d_ff && idx_d_ff == PKT_LAST_IDX;

    always_comb begin
        nxt_tx = tx_ff;
        case (tx_ff)
            TX_IDLE: begin
                if (ctl_go || aux_go) begin
                    nxt_tx = TX_RUN;
                end
            end
            TX_RUN: begin
                if (idx_ff == PKT_LAST_IDX) begin
                    nxt_tx = TX_IDLE;
                end
            end
            default: nxt_tx = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_ff <= TX_IDLE;
            idx_ff <= 6'h00;
            ctl_ff <= 1'b0;
        end else begin
            tx_ff <= nxt_tx;
            if (tx_ff == TX_IDLE) begin
                idx_ff <= 6'h00;
                ctl_ff <= ctl_go;
            end else begin
                idx_ff <= idx_ff + 6'h01;
            end
        end
    end

    logic out_valid_ff, out_first_ff, out_last_ff, out_par_ff;
    logic [7:0] out_byte_ff;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            run_d_ff <= 1'b0;
            idx_d_ff <= 6'h00;
            ctl_d_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_first_ff <= 1'b0;
            out_last_ff <= 1'b0;
            out_par_ff <= 1'b0;
            out_byte_ff <= 8'h00;
        end else begin
            run_d_ff <= (tx_ff == TX_RUN);
            idx_d_ff <= idx_ff;
            ctl_d_ff <= ctl_ff;
            out_valid_ff <= run_d_ff;
            out_first_ff <= run_d_ff && idx_d_ff == 6'h00;
            out_last_ff <= run_d_ff && idx_d_ff == PKT_LAST_IDX;
            out_par_ff <= run_d_ff && is_par_d;
            out_byte_ff <= run_d_ff ? sel_byte : 8'h00;
        end
    end

    apf_store apf_store_i (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(wr_fire),
        .wr_addr(wr_cnt_ff),
        .wr_data(pkt_word),
        .rd_addr(rd_word),
        .rd_data(rd_data)
    );

    apf_ecc apf_ecc_i (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clr(!run_d_ff || is_par_d),
        .en(run_d_ff && !is_par_d),
        .data_in(data_d),
        .parity(ecc_val)
    );

    // Sink configuration write over the display data channel.
    apf_i2c_state_t i2_ff, nxt_i2;
    logic pres_d_ff, cfg_pend_ff, scr_ff, ratio_ff, nack_ff;
    logic scl_oe_ff, sda_oe_ff, busy_ff;
    logic [8:0] qtr_ff;
    logic [1:0] ph_ff;
    logic [4:0] bit_ff;
    logic [26:0] shift_ff;
    logic pres_rise, qtr_tick, stretch, ack_slot, i2_go;
    logic nxt_scl_oe, nxt_sda_oe;

    assign pres_rise = sink_presence_detect && !pres_d_ff;
    assign i2_go = (i2_ff == I2_IDLE) && cfg_pend_ff && sink_presence_detect;
    // A sink holding the clock low stretches the high phase of a bit.
    assign stretch = (i2_ff == I2_BIT) && ph_ff == 2'h1 && !ddc_scl_in;
    assign qtr_tick = (qtr_ff == I2C_QTR_LAST) && !stretch;
    assign ack_slot = bit_ff == ACK_SLOT0 || bit_ff == ACK_SLOT1 ||
                      bit_ff == ACK_SLOT2;

    always_comb begin
        nxt_i2 = i2_ff;
        nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;
        case (i2_ff)
            I2_IDLE: begin
                nxt_scl_oe = 1'b0;
                nxt_sda_oe = 1'b0;
                if (i2_go) begin
                    nxt_i2 = I2_START;
                end
            end
            I2_START: begin
                nxt_sda_oe = ph_ff >= 2'h2;
                nxt_scl_oe = ph_ff == 2'h3;
                if (qtr_tick && ph_ff == 2'h3) begin
                    nxt_i2 = I2_BIT;
                end
            end
            I2_BIT: begin
                nxt_scl_oe = ph_ff == 2'h0 || ph_ff == 2'h3;
                nxt_sda_oe = !shift_ff[26];
                if (qtr_tick && ph_ff == 2'h3 && bit_ff == I2C_LAST_BIT) begin
                    nxt_i2 = I2_STOP;
                end
            end
            I2_STOP: begin
                nxt_scl_oe = ph_ff == 2'h0;
                nxt_sda_oe = ph_ff <= 2'h1;
                if (qtr_tick && ph_ff == 2'h3) begin
                    nxt_i2 = I2_IDLE;
                end
            end
            default: nxt_i2 = I2_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            i2_ff <= I2_IDLE;
            pres_d_ff <= 1'b0;
            busy_ff <= 1'b0;
            cfg_pend_ff <= 1'b0;
            scr_ff <= 1'b0;
            ratio_ff <= 1'b0;
            nack_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            qtr_ff <= 9'h000;
            ph_ff <= 2'h0;
            bit_ff <= 5'h00;
            shift_ff <= 27'h7ff_ffff;
        end else begin
            i2_ff <= nxt_i2;
            pres_d_ff <= sink_presence_detect;
            busy_ff <= nxt_i2 != I2_IDLE;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            if (pres_rise || stream_start) begin
                cfg_pend_ff <= 1'b1;
            end else if (i2_go) begin
                cfg_pend_ff <= 1'b0;
            end
            if (i2_go) begin
                scr_ff <= version_2p0;
                ratio_ff <= version_2p0;
                nack_ff <= 1'b0;
                shift_ff <= {SINK_WR_ADDR, 1'b1, SINK_CFG_OFFSET, 1'b1,
                             6'h00, version_2p0, version_2p0, 1'b1};
            end
            if (i2_ff == I2_IDLE) begin
                qtr_ff <= 9'h000;
                ph_ff <= 2'h0;
                bit_ff <= 5'h00;
            end else if (qtr_tick) begin
                qtr_ff <= 9'h000;
                ph_ff <= ph_ff + 2'h1;
                if (i2_ff == I2_BIT && ph_ff == 2'h2 && ack_slot
                        && ddc_sda_in) begin
                    nack_ff <= 1'b1;
                end
                if (i2_ff == I2_BIT && ph_ff == 2'h3) begin
                    bit_ff <= bit_ff + 5'h01;
                    shift_ff <= {shift_ff[25:0], 1'b1};
                end else if (i2_ff != I2_BIT && ph_ff == 2'h3) begin
                    bit_ff <= 5'h00;
                end
            end else if (!stretch) begin
                qtr_ff <= qtr_ff + 9'h001;
            end
        end
    end

    assign pkt_ready = ready_ff;
    assign aux_type_unknown = unknown_ff;
    assign out_valid = out_valid_ff;
    assign out_byte = out_byte_ff;
    assign out_first = out_first_ff;
    assign out_last = out_last_ff;
    assign out_parity = out_par_ff;
    assign scrambler_enable = scr_ff;
    assign link_clock_ratio_flag = ratio_ff;
    assign sink_cfg_busy = busy_ff;
    assign sink_nack = nack_ff;
    assign ddc_scl_out = 1'b0;
    assign ddc_sda_out = 1'b0;
    assign ddc_scl_oe = scl_oe_ff;
    assign ddc_sda_oe = sda_oe_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_pkt_length: assert property (
        out_first |-> ##35 out_last)
        else $error("packet not 36 bytes long");
    chk_parity_slots: assert property (
        out_first |-> ##3 out_parity ##8 out_parity ##8 out_parity
                      ##8 out_parity ##8 out_parity)
        else $error("parity byte out of place");
    chk_hdr_parity: assert property (
        out_first |-> !out_parity ##1 !out_parity ##1 !out_parity)
        else $error("header data byte flagged as parity");
    chk_ctl_type: assert property (
        ctl_go |-> ##3 (out_first && out_byte == TYPE_GEN_CTRL))
        else $error("control packet type byte wrong");
    chk_ctl_deadline: assert property (
        ctl_wait_ff < 9'(CTL_DEADLINE_CYC))
        else $error("control packet late after vsync");
    chk_store_held: assert property (
        (full_ff && tx_ff == TX_IDLE && !tx_done) |=> full_ff && !pkt_ready)
        else $error("stored packet released before sending");
    chk_no_interleave: assert property (
        (tx_ff == TX_RUN && idx_ff == 6'h02) |=> !out_first [*8])
        else $error("packet start inside another packet");
    chk_scramble_match: assert property (
        i2_go |=> scrambler_enable == $past(version_2p0)
                  && link_clock_ratio_flag == scrambler_enable)
        else $error("scrambler and sink flags disagree");
    chk_cfg_word: assert property (
        i2_go |=> shift_ff[17:10] == SINK_CFG_OFFSET
                  && shift_ff[CFG_RATIO_BIT + 1] == ratio_ff)
        else $error("sink register write malformed");
    chk_presence_start: assert property (
        (pres_rise && i2_ff == I2_IDLE) |=> ##1 i2_ff == I2_START)
        else $error("presence detect did not start channel");
endmodule
`default_nettype wire

// *** hdl/apf_pkg.sv ***
/*
 * Constants shared by the auxiliary packet framer: packet geometry, packet
 * type codes, parity polynomial, sink register layout and timing counts.
 * Assumes a 125 MHz system clock.
 */
package apf_pkg;
    localparam int CLK_NS = 8;
    localparam int PKT_WORDS = 9;
    localparam logic [5:0] PKT_LAST_IDX = 6'h23;
    localparam logic [5:0] HDR_PARITY_IDX = 6'h03;
    localparam logic [5:0] BODY_FIRST_IDX = 6'h04;
    localparam logic [3:0] WORD_LAST = 4'h8;
    localparam logic [7:0] BCH_POLY = 8'h83;
    // Packet type codes carried in the header type byte.
    localparam logic [7:0] TYPE_NULL = 8'h00;
    localparam logic [7:0] TYPE_CLK_REGEN = 8'h01;
    localparam logic [7:0] TYPE_AUDIO = 8'h02;
    localparam logic [7:0] TYPE_GEN_CTRL = 8'h03;
    localparam logic [7:0] TYPE_AUDIO_META = 8'h0d;
    localparam logic [7:0] TYPE_INFOFRAME = 8'h80;
    localparam logic [7:0] IF_VENDOR = 8'h01;
    localparam logic [7:0] IF_VIDEO = 8'h02;
    localparam logic [7:0] IF_AUDIO = 8'h04;
    localparam logic [7:0] IF_DRM = 8'h07;
    // Sink status and control space.
    localparam logic [7:0] SINK_WR_ADDR = 8'ha8;
    localparam logic [7:0] SINK_CFG_OFFSET = 8'h20;
    localparam int CFG_SCRAMBLE_BIT = 0;
    localparam int CFG_RATIO_BIT = 1;
    localparam logic [4:0] I2C_LAST_BIT = 5'h1a;
    localparam logic [4:0] ACK_SLOT0 = 5'h08;
    localparam logic [4:0] ACK_SLOT1 = 5'h11;
    localparam logic [4:0] ACK_SLOT2 = 5'h1a;
    localparam int I2C_BIT_NS = 10000;
    localparam int I2C_QTR_CYC = I2C_BIT_NS / 4 / CLK_NS;
    localparam logic [8:0] I2C_QTR_LAST = 9'(I2C_QTR_CYC - 1);
    localparam int CTL_DEADLINE_CYC = 384;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_RUN = 2'b10
    } apf_tx_state_t;

    typedef enum logic [3:0] {
        I2_IDLE = 4'b0001,
        I2_START = 4'b0010,
        I2_BIT = 4'b0100,
        I2_STOP = 4'b1000
    } apf_i2c_state_t;
endpackage

// *** hdl/apf_ecc.sv ***
/*
 * Serial BCH parity generator for one header or subpacket, eight bits per
 * clock, least significant bit first. Assumes the caller clears it before
 * each protected group.
 */
`timescale 1ns/100ps
`default_nettype none
module apf_ecc
    import apf_pkg::*;
(
    input wire logic clk_sys,       // System clock.
    input wire logic reset_n,       // Synchronous reset, active low.
    input wire logic clr,           // Restart the parity for a new group.
    input wire logic en,            // Fold data_in into the parity.
    input wire logic [7:0] data_in, // Data byte being sent.
    output logic [7:0] parity       // Parity over the bytes folded so far.
);
    logic [7:0] parity_ff;
    logic [7:0] nxt_parity;

    function automatic logic [7:0] bch_step(input logic [7:0] r,
                                            input logic [7:0] d);
        logic [7:0] acc;
        logic fb;
        acc = r;
        for (int i = 0; i < 8; i++) begin
            fb = d[i] ^ acc[0];
            acc = {1'b0, acc[7:1]} ^ (fb ? BCH_POLY : 8'h00);
        end
        return acc;
    endfunction

    assign nxt_parity = clr ? 8'h00 :
                        en ? bch_step(parity_ff, data_in) : parity_ff;
    assign parity = parity_ff;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            parity_ff <= 8'h00;
        end else begin
            parity_ff <= nxt_parity;
        end
    end
endmodule
`default_nettype wire

// *** hdl/apf_store.sv ***
/*
 * Nine-word store for one supplied packet with registered read data.
 * Assumes the writer never overwrites a packet that is being read out.
 */
`timescale 1ns/100ps
`default_nettype none
module apf_store
    import apf_pkg::*;
(
    input wire logic clk_sys,          // System clock.
    input wire logic reset_n,          // Synchronous reset, active low.
    input wire logic wr_en,            // Write strobe.
    input wire logic [3:0] wr_addr,    // Word index written.
    input wire logic [31:0] wr_data,   // Word written.
    input wire logic [3:0] rd_addr,    // Word index read.
    output logic [31:0] rd_data        // Word read, one cycle later.
);
    logic [31:0] mem_ff [PKT_WORDS];
    logic [31:0] rd_data_ff;

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_data_ff <= 32'h0000_0000;
        end else begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

// *** bench/apf_sink_model.sv ***
/*
 * Behavioural sink on the display data channel: acknowledges every byte
 * and keeps the last three bytes received. Assumes pulled-up wires.
 */
`timescale 1ns/100ps
`default_nettype none
module apf_sink_model (
    input wire logic scl,      // Channel clock wire level.
    input wire logic sda,      // Channel data wire level.
    output logic ack_oe,       // High while the sink pulls data low.
    output logic [23:0] rx     // Last three bytes, oldest highest.
);
    logic [3:0] n_bit;
    logic [7:0] sh;
    initial begin
        ack_oe = 1'b0;
        n_bit = 4'h0;
        rx = 24'h000000;
    end
    // Data falling with the clock high starts a new transfer.
    always @(negedge sda) if (scl) n_bit = 4'h0;
    always @(posedge scl) if (n_bit < 4'h8) begin
        sh = {sh[6:0], sda};
        n_bit = n_bit + 4'h1;
    end
    always @(negedge scl) begin
        if (n_bit == 4'h8 && !ack_oe) begin
            ack_oe = 1'b1;
            rx = {rx[15:0], sh};
        end else if (ack_oe) begin
            ack_oe = 1'b0;
            n_bit = 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** bench/test_aux_packet_ecc_framer.sv ***
/*
 * Self-checking bench for the packet framer: a supplied packet, the
 * control packet and two sink register writes. Assumes apf_sink_model.
 */
`timescale 1ns/100ps
`default_nettype none
module test_aux_packet_ecc_framer;
    import apf_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, pkt_valid = 1'b0, vsync = 1'b0;
    logic island_open = 1'b0, avmute_set = 1'b0, avmute_clear = 1'b0;
    logic stream_start = 1'b0, version_2p0 = 1'b0, sink_presence_detect = 1'b0;
    logic [31:0] pkt_word = 32'h00000000;
    logic pkt_ready, aux_type_unknown, out_valid, out_first, out_last;
    logic out_parity, scrambler_enable, link_clock_ratio_flag, sink_cfg_busy;
    logic sink_nack, scl_oe, sda_oe, ack_oe;
    logic [7:0] out_byte;
    logic [23:0] rx;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || ack_oe);
    int n_mismatch = 0, checks = 0;
    logic [7:0] got [0:35];
    logic [35:0] par;
    always #4 clk_sys = ~clk_sys;
    apf_framer apf_framer_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .pkt_valid(pkt_valid), .pkt_word(pkt_word), .pkt_ready(pkt_ready),
        .aux_type_unknown(aux_type_unknown), .island_open(island_open),
        .vsync(vsync), .avmute_set(avmute_set), .avmute_clear(avmute_clear),
        .out_valid(out_valid), .out_byte(out_byte), .out_first(out_first),
        .out_last(out_last), .out_parity(out_parity),
        .stream_start(stream_start), .version_2p0(version_2p0),
        .sink_presence_detect(sink_presence_detect),
        .scrambler_enable(scrambler_enable),
        .link_clock_ratio_flag(link_clock_ratio_flag),
        .sink_cfg_busy(sink_cfg_busy), .sink_nack(sink_nack),
        .ddc_scl_in(scl), .ddc_scl_out(), .ddc_scl_oe(scl_oe),
        .ddc_sda_in(sda), .ddc_sda_out(), .ddc_sda_oe(sda_oe));
    apf_sink_model apf_sink_model_i (.scl(scl), .sda(sda), .ack_oe(ack_oe),
        .rx(rx));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic cmp(logic [31:0] g, logic [31:0] e);
        checks++;
        if (g !== e) begin
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
            n_mismatch++;
        end
    endtask
    task automatic wait_is(ref logic s, input logic v, input int lim);
        int w;
        w = 0;
        while (s !== v) begin
            if (w == lim) begin
                n_mismatch++;
                end_of_test();
            end
            step(1);
            w++;
        end
    endtask
    // Serial parity, least significant bit first, shifting right.
    function automatic logic [7:0] bch(logic [7:0] p, logic [7:0] d);
        logic fb;
        for (int b = 0; b < 8; b++) begin
            fb = p[0] ^ d[b];
            p = (p >> 1) ^ (fb ? BCH_POLY : 8'h00);
        end
        return p;
    endfunction
    task automatic grab_chk(int lim, logic [23:0] hdr, logic [223:0] body);
        logic [7:0] p, e;
        wait_is(out_first, 1'b1, lim);
        for (int i = 0; i < 36; i++) begin
            got[i] = out_byte;
            par[i] = out_parity;
            cmp(out_valid, 1'b1);
            cmp(out_last, i == 35);
            step(1);
        end
        p = 8'h00;
        for (int i = 0; i < 36; i++) begin
            if (i % 8 == 3) e = p;
            else e = (i < 3) ? hdr[8*i +: 8] : body[8*(i-4-(i-4)/8) +: 8];
            cmp(got[i], e);
            cmp(par[i], i % 8 == 3);
            p = (i % 8 == 3) ? 8'h00 : bch(p, e);
        end
    endtask
    task automatic t_supplied();
        logic [23:0] hdr;
        logic [255:0] bw;
        hdr = {8'h5a, 8'h3c, TYPE_INFOFRAME + IF_DRM};
        bw = {256{1'b1}};
        for (int n = 0; n < 28; n++) bw[8*n +: 8] = 8'(8'h10 + n);
        wait_is(pkt_ready, 1'b1, 4);
        pkt_valid = 1'b1;
        for (int k = 0; k < 9; k++) begin
            pkt_word = (k == 0) ? {8'hee, hdr} : bw[32*(k-1) +: 32];
            step(1);
        end
        pkt_valid = 1'b0;
        cmp(pkt_ready, 1'b0);
        cmp(aux_type_unknown, 1'b0);
        step(5);
        cmp(out_valid, 1'b0);
        island_open = 1'b1;
        grab_chk(8, hdr, bw[223:0]);
        $display("test supplied done");
    endtask
    task automatic t_control();
        avmute_set = 1'b1;
        avmute_clear = 1'b1;
        vsync = 1'b1;
        grab_chk(CTL_DEADLINE_CYC, {16'h0000, TYPE_GEN_CTRL}, 224'h11);
        vsync = 1'b0;
        $display("test control done");
    endtask
    task automatic t_sink(logic v, logic by_start);
        version_2p0 = v;
        if (by_start) stream_start = 1'b1;
        else sink_presence_detect = 1'b1;
        step(1);
        stream_start = 1'b0;
        wait_is(sink_cfg_busy, 1'b1, 20);
        wait_is(sink_cfg_busy, 1'b0, 50000);
        cmp(rx, {SINK_WR_ADDR, SINK_CFG_OFFSET, 6'h00, v, v});
        cmp(scrambler_enable, v);
        cmp(link_clock_ratio_flag, v);
        cmp(sink_nack, 1'b0);
        $display("test sink write done");
    endtask
    initial begin
        step(2);
        reset_n = 1'b1;
        step(1);
        t_supplied();
        t_control();
        t_sink(1'b1, 1'b0);
        t_sink(1'b0, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
